// file: src/flash_suspend_consts.svh
`ifndef FLASH_SUSPEND_CONSTS_SVH
`define FLASH_SUSPEND_CONSTS_SVH
// Register indices on the plain port
`define ADDR_CTRL_STATUS 4'h0
`define ADDR_MODE 4'h1
`define ADDR_SUSPEND 4'h2
`define ADDR_COMMAND 4'h3
`define ADDR_ID_STATUS 4'h4
`define ADDR_ID_EXPECT 4'h5
// Control/status fields
`define BIT_READY 0
`define BIT_CPU_REWRITE 1
`define BIT_BLOCK0_REWRITE 2
`define BIT_TOLERANT 1
`define BIT_SUSP_EN 0
`define BIT_ERASE_SUSP 1
`define BIT_PROG_SUSP 2
`define BIT_BUSY 3
// Command codes
`define CMD_PROGRAM 8'h40
`define CMD_ERASE 8'hD0
// Timing (ns) and cycle counts at a 10 ns clock
`define CLOCK_PERIOD_NS 10
`define SUSPEND_LATENCY_NS 200
`define SUSPEND_LATENCY_CYC ((`SUSPEND_LATENCY_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define ABORT_DELAY_NS 300
`define ABORT_DELAY_CYC ((`ABORT_DELAY_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define OP_CYCLES_DEFAULT 1000
`endif

// file: src/flash_suspend_pkg.sv
package flash_suspend_pkg;
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_RUN,
      ST_WAIT_SUS,
      ST_SUSPENDED,
      ST_ABORT
   } seq_state_e;
   typedef enum logic [1:0] {
      OP_NONE,
      OP_ERASE,
      OP_PROGRAM
   } op_kind_e;
endpackage

// file: src/serial_id_check.sv
`timescale 1ns/100ps
`include "flash_suspend_consts.svh"
// Serial identification check: shifts in bits, compares with stored codes
module serial_id_check #(
   parameter int ID_BYTES = 7
) (
   input wire logic clock, // System clock
   input wire logic reset, // Async reset, high
   input wire logic bit_valid, // One received bit
   input wire logic bit_value, // Received bit value
   input wire logic [8*ID_BYTES-1:0] id_stored, // Codes held in flash
   output logic id_match, // Full code received and equal
   output logic id_done // Full code received
);
   localparam int NBITS = 8 * ID_BYTES;
   logic [NBITS-1:0] shift_r;
   logic [$clog2(NBITS+1)-1:0] count_r;
   generate
      if (ID_BYTES < 1) begin : g_bad_id_bytes
         $error("ID_BYTES must be positive");
      end
   endgenerate
   // Shift received bits until the whole code is in
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         shift_r <= '0;
         count_r <= '0;
      end else if (bit_valid && count_r != NBITS[$clog2(NBITS+1)-1:0]) begin
         shift_r <= {shift_r[NBITS-2:0], bit_value};
         count_r <= count_r + 1'b1;
      end
   end
   // Access permitted only on a full matching code
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         id_match <= 1'b0;
         id_done <= 1'b0;
      end else begin
         id_done <= (count_r == NBITS[$clog2(NBITS+1)-1:0]);
         id_match <= (count_r == NBITS[$clog2(NBITS+1)-1:0]) && (shift_r == id_stored);
      end
   end
endmodule

// file: src/flash_rewrite_suspend_control.sv
`timescale 1ns/100ps
`include "flash_suspend_consts.svh"
// Function
// - Suspend only with suspend enable set; triggering interrupt enabled beforehand.
// - In tolerant mode, suspend is entered from an enabled interrupt request.
// - With suspend enabled, acknowledge comes after the suspend latency.
// - Interrupt during erase sets erase suspend request and pauses erase.
// - Clearing erase suspend request while not ready resumes the erase.
// - Interrupt during program sets program suspend request and pauses it.
// - Clearing program suspend request while not ready resumes programming.
// - Suspend disabled: maskable acknowledge waits until the operation completes.
// - Non-maskable acknowledge aborts the operation, resets flash, delays restart.
// - Serial programmer mode grants access only on matching ID codes.
// - Second serial mode: mode pin low, separate data out and in pins.
// - Third serial mode: mode pin is the bidirectional serial data line.
// - Mode pin high at reset release starts single-chip execution from flash.
module flash_rewrite_suspend_control #(
   parameter int OP_CYCLES = `OP_CYCLES_DEFAULT,
   parameter int ID_BYTES = 7
) (
   input wire logic clock, // System clock 100 MHz
   input wire logic reset, // Async reset, high
   input wire logic [3:0] reg_addr, // Register index
   input wire logic [7:0] reg_wdata, // Write data
   input wire logic reg_write, // Write strobe
   input wire logic reg_read, // Read strobe
   output logic [7:0] reg_rdata, // Read data, cycle after strobe
   input wire logic irq_request, // Maskable interrupt request level
   input wire logic irq_enabled, // Request enabled in controller
   output logic irq_ack, // Maskable acknowledge pulse
   input wire logic nmi_request, // Non-maskable request pulse
   output logic nmi_ack, // Non-maskable handling start pulse
   output logic flash_reset, // Flash core reset during abort
   input wire logic mode_pin_in, // Mode pin level
   output logic mode_pin_out, // Mode pin drive value
   output logic mode_pin_oe, // Mode pin drive enable
   input wire logic rxd_in, // Serial data in, mode 2
   output logic txd_out, // Serial data out, mode 2
   input wire logic serial_bit_strobe, // Sample strobe from pin
   input wire logic serial_mode_sel, // 0 mode 2, 1 mode 3
   input wire logic [8*ID_BYTES-1:0] id_stored, // Stored identification codes
   output logic single_chip_run, // Run from flash after reset
   output logic programmer_access // Programmer access granted
);
   localparam int SUS_CYC = `SUSPEND_LATENCY_CYC;
   localparam int ABT_CYC = `ABORT_DELAY_CYC;
   localparam int CW = $clog2(OP_CYCLES + SUS_CYC + ABT_CYC + 2);

   flash_suspend_pkg::seq_state_e state_r;
   flash_suspend_pkg::op_kind_e op_r;
   logic [CW-1:0] op_cnt_r;
   logic [CW-1:0] wait_cnt_r;
   logic cpu_rewrite_enable_r;
   logic block0_rewrite_enable_r;
   logic tolerant_mode_select_r;
   logic suspend_enable_bit_r;
   logic erase_suspend_request_r;
   logic program_suspend_request_r;
   logic irq_pending_r;
   logic [1:0] pin_sync_r;
   logic [1:0] rxd_sync_r;
   logic [1:0] strobe_sync_r;
   logic strobe_prev_r;
   logic boot_seen_r;
   logic id_match;
   logic id_done;
   logic sequencer_ready_flag;
   logic busy;
   logic resume_req;
   logic serial_bit;

   // Refuse an operation length the counter cannot serve
   generate
      if (OP_CYCLES < 1) begin : g_bad_op_cycles
         $error("OP_CYCLES must be positive");
      end
   endgenerate

   assign sequencer_ready_flag = (state_r == flash_suspend_pkg::ST_IDLE);
   assign busy = !sequencer_ready_flag;

   // Resume when software clears the request that caused suspend
   always_comb begin
      resume_req = 1'b0;
      if (reg_write && reg_addr == `ADDR_SUSPEND && state_r == flash_suspend_pkg::ST_SUSPENDED) begin
         if (op_r == flash_suspend_pkg::OP_ERASE)
            resume_req = !reg_wdata[`BIT_ERASE_SUSP];
         else
            resume_req = !reg_wdata[`BIT_PROG_SUSP];
      end
   end

   // Control bits: cleared by write 0, set by a later write 1; tolerant select sets only with CPU rewrite enabled
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         cpu_rewrite_enable_r <= 1'b0;
         block0_rewrite_enable_r <= 1'b0;
         tolerant_mode_select_r <= 1'b0;
         suspend_enable_bit_r <= 1'b0;
      end else if (reg_write) begin
         if (reg_addr == `ADDR_CTRL_STATUS) begin
            cpu_rewrite_enable_r <= reg_wdata[`BIT_CPU_REWRITE];
            block0_rewrite_enable_r <= reg_wdata[`BIT_BLOCK0_REWRITE];
         end else if (reg_addr == `ADDR_MODE) begin
            tolerant_mode_select_r <= reg_wdata[`BIT_TOLERANT] && cpu_rewrite_enable_r;
         end else if (reg_addr == `ADDR_SUSPEND) begin
            suspend_enable_bit_r <= reg_wdata[`BIT_SUSP_EN];
         end
      end
   end

   // Sequencer: run, suspend latency, suspended, forced abort
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         state_r <= flash_suspend_pkg::ST_IDLE;
         op_r <= flash_suspend_pkg::OP_NONE;
         op_cnt_r <= '0;
         wait_cnt_r <= '0;
      end else if (nmi_request && busy && state_r != flash_suspend_pkg::ST_ABORT) begin
         state_r <= flash_suspend_pkg::ST_ABORT;
         op_r <= flash_suspend_pkg::OP_NONE;
         wait_cnt_r <= '0;
      end else begin
         case (state_r)
            flash_suspend_pkg::ST_IDLE: begin
               if (reg_write && reg_addr == `ADDR_COMMAND && cpu_rewrite_enable_r) begin
                  if (reg_wdata == `CMD_ERASE) begin
                     state_r <= flash_suspend_pkg::ST_RUN;
                     op_r <= flash_suspend_pkg::OP_ERASE;
                     op_cnt_r <= '0;
                  end else if (reg_wdata == `CMD_PROGRAM) begin
                     state_r <= flash_suspend_pkg::ST_RUN;
                     op_r <= flash_suspend_pkg::OP_PROGRAM;
                     op_cnt_r <= '0;
                  end
               end
            end
            flash_suspend_pkg::ST_RUN: begin
               if (op_cnt_r == CW'(OP_CYCLES - 1)) begin
                  state_r <= flash_suspend_pkg::ST_IDLE;
                  op_r <= flash_suspend_pkg::OP_NONE;
               end else begin
                  op_cnt_r <= op_cnt_r + 1'b1;
                  if (irq_request && irq_enabled && suspend_enable_bit_r && tolerant_mode_select_r) begin
                     state_r <= flash_suspend_pkg::ST_WAIT_SUS;
                     wait_cnt_r <= '0;
                  end
               end
            end
            flash_suspend_pkg::ST_WAIT_SUS: begin
               if (wait_cnt_r == CW'(SUS_CYC - 1))
                  state_r <= flash_suspend_pkg::ST_SUSPENDED;
               else
                  wait_cnt_r <= wait_cnt_r + 1'b1;
            end
            flash_suspend_pkg::ST_SUSPENDED: begin
               if (resume_req)
                  state_r <= flash_suspend_pkg::ST_RUN;
            end
            flash_suspend_pkg::ST_ABORT: begin
               if (wait_cnt_r == CW'(ABT_CYC - 1))
                  state_r <= flash_suspend_pkg::ST_IDLE;
               else
                  wait_cnt_r <= wait_cnt_r + 1'b1;
            end
            default: state_r <= flash_suspend_pkg::ST_IDLE;
         endcase
      end
   end

   // Suspend request bits: hardware set wins over software clear
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         erase_suspend_request_r <= 1'b0;
         program_suspend_request_r <= 1'b0;
      end else if (state_r == flash_suspend_pkg::ST_RUN && irq_request && irq_enabled
                   && suspend_enable_bit_r && tolerant_mode_select_r && op_cnt_r != CW'(OP_CYCLES - 1)) begin
         if (op_r == flash_suspend_pkg::OP_ERASE)
            erase_suspend_request_r <= 1'b1;
         else
            program_suspend_request_r <= 1'b1;
      end else if (state_r == flash_suspend_pkg::ST_ABORT || state_r == flash_suspend_pkg::ST_IDLE) begin
         erase_suspend_request_r <= 1'b0;
         program_suspend_request_r <= 1'b0;
      end else if (reg_write && reg_addr == `ADDR_SUSPEND) begin
         if (!reg_wdata[`BIT_ERASE_SUSP])
            erase_suspend_request_r <= 1'b0;
         if (!reg_wdata[`BIT_PROG_SUSP])
            program_suspend_request_r <= 1'b0;
      end
   end

   // Maskable acknowledge: after latency, or held until completion
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         irq_ack <= 1'b0;
         irq_pending_r <= 1'b0;
      end else begin
         irq_ack <= 1'b0;
         if (state_r == flash_suspend_pkg::ST_WAIT_SUS && wait_cnt_r == CW'(SUS_CYC - 1)) begin
            irq_ack <= 1'b1;
            irq_pending_r <= 1'b0;
         end else if (irq_request && irq_enabled && !irq_pending_r && !irq_ack) begin
            if (sequencer_ready_flag || state_r == flash_suspend_pkg::ST_SUSPENDED)
               irq_ack <= 1'b1;
            else if (!suspend_enable_bit_r || !tolerant_mode_select_r)
               irq_pending_r <= 1'b1;
         end else if (irq_pending_r && sequencer_ready_flag) begin
            irq_ack <= 1'b1;
            irq_pending_r <= 1'b0;
         end
      end
   end

   // Abort outputs: flash reset during delay, handling starts at its end
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         flash_reset <= 1'b0;
         nmi_ack <= 1'b0;
      end else begin
         flash_reset <= (state_r == flash_suspend_pkg::ST_ABORT);
         nmi_ack <= (state_r == flash_suspend_pkg::ST_ABORT) && (wait_cnt_r == CW'(ABT_CYC - 1));
      end
   end

   // Mode pin synchroniser keeps running through reset, so the boot sample sees the settled pin
   always_ff @(posedge clock) begin
      pin_sync_r <= {pin_sync_r[0], mode_pin_in};
   end

   // Serial pin synchronisers
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         rxd_sync_r <= 2'h3;
         strobe_sync_r <= 2'h0;
         strobe_prev_r <= 1'b0;
      end else begin
         rxd_sync_r <= {rxd_sync_r[0], rxd_in};
         strobe_sync_r <= {strobe_sync_r[0], serial_bit_strobe};
         strobe_prev_r <= strobe_sync_r[1];
      end
   end

   // Mode pin sampled after reset release picks single-chip or programmer
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         boot_seen_r <= 1'b0;
         single_chip_run <= 1'b0;
      end else if (!boot_seen_r) begin
         boot_seen_r <= 1'b1;
         single_chip_run <= pin_sync_r[1];
      end
   end

   // Serial data source: separate pin in mode 2, mode pin in mode 3
   assign serial_bit = serial_mode_sel ? pin_sync_r[1] : rxd_sync_r[1];

   serial_id_check #(
      .ID_BYTES(ID_BYTES)
   ) u_id (
      .clock(clock),
      .reset(reset),
      .bit_valid(strobe_sync_r[1] && !strobe_prev_r && boot_seen_r && !single_chip_run),
      .bit_value(serial_bit),
      .id_stored(id_stored),
      .id_match(id_match),
      .id_done(id_done)
   );

   // Answer pins: mode 3 answers on the mode pin, mode 2 on the output pin
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         mode_pin_out <= 1'b1;
         mode_pin_oe <= 1'b0;
         txd_out <= 1'b1;
         programmer_access <= 1'b0;
      end else begin
         programmer_access <= id_match && !single_chip_run;
         mode_pin_oe <= serial_mode_sel && id_done && !single_chip_run;
         mode_pin_out <= id_match;
         txd_out <= serial_mode_sel ? 1'b1 : id_match;
      end
   end

   // Register read data, one cycle after strobe
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         reg_rdata <= 8'h00;
      end else if (reg_read) begin
         if (reg_addr == `ADDR_CTRL_STATUS)
            reg_rdata <= {5'h00, block0_rewrite_enable_r, cpu_rewrite_enable_r, sequencer_ready_flag};
         else if (reg_addr == `ADDR_MODE)
            reg_rdata <= {6'h00, tolerant_mode_select_r, 1'b0};
         else if (reg_addr == `ADDR_SUSPEND)
            reg_rdata <= {4'h0, busy, program_suspend_request_r, erase_suspend_request_r, suspend_enable_bit_r};
         else if (reg_addr == `ADDR_ID_STATUS)
            reg_rdata <= {5'h00, single_chip_run, id_done, id_match};
         else
            reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // Checks
   chk_suspend_needs_enable: assert property (@(posedge clock) disable iff (reset)
      $rose(erase_suspend_request_r) |-> $past(suspend_enable_bit_r))
      else $error("suspend without enable");
   chk_erase_sets_request: assert property (@(posedge clock) disable iff (reset)
      (state_r == flash_suspend_pkg::ST_WAIT_SUS && op_r == flash_suspend_pkg::OP_ERASE) |-> erase_suspend_request_r)
      else $error("erase suspend request not set");
   chk_prog_sets_request: assert property (@(posedge clock) disable iff (reset)
      (state_r == flash_suspend_pkg::ST_WAIT_SUS && op_r == flash_suspend_pkg::OP_PROGRAM) |-> program_suspend_request_r)
      else $error("program suspend request not set");
   chk_ack_latency: assert property (@(posedge clock) disable iff (reset)
      $rose(state_r == flash_suspend_pkg::ST_WAIT_SUS) && !nmi_request |-> ##20 irq_ack)
      else $error("acknowledge not at suspend latency");
   chk_no_early_ack: assert property (@(posedge clock) disable iff (reset)
      state_r == flash_suspend_pkg::ST_WAIT_SUS |-> !irq_ack)
      else $error("acknowledge inside suspend latency");
   chk_held_while_busy: assert property (@(posedge clock) disable iff (reset)
      irq_pending_r && busy |=> !irq_ack)
      else $error("held interrupt acknowledged early");
   chk_resume_erase: assert property (@(posedge clock) disable iff (reset)
      resume_req && !nmi_request |=> state_r == flash_suspend_pkg::ST_RUN)
      else $error("no resume after clear");
   chk_abort_reset: assert property (@(posedge clock) disable iff (reset)
      nmi_request && busy && state_r != flash_suspend_pkg::ST_ABORT |=> ##1 flash_reset)
      else $error("abort did not reset flash");
   chk_access_on_match: assert property (@(posedge clock) disable iff (reset)
      programmer_access |-> $past(id_match))
      else $error("access without match");
   cov_erase_suspend: cover property (@(posedge clock) disable iff (reset)
      state_r == flash_suspend_pkg::ST_SUSPENDED && op_r == flash_suspend_pkg::OP_ERASE);
   cov_abort: cover property (@(posedge clock) disable iff (reset) nmi_ack);
   cov_pending: cover property (@(posedge clock) disable iff (reset) $fell(irq_pending_r));
endmodule

// file: testbench/cpu_irq_model.sv
`timescale 1ns/100ps
// Interrupt controller on the CPU side: raises, holds and drops requests
module cpu_irq_model (
   input wire logic clock, // System clock
   input wire logic reset, // Async reset, high
   input wire logic raise_irq, // Bench asks for a maskable request
   input wire logic fire_nmi, // Bench asks for a non-maskable event
   input wire logic irq_ack, // Acknowledge from the block
   output logic irq_request, // Request level, held until acknowledged
   output logic irq_enabled, // Source enabled in the controller
   output logic nmi_request, // One-cycle non-maskable pulse
   output int irq_wait // Cycles the last request waited
);
   // Source is enabled from the first edge on, ahead of any request
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         irq_enabled <= 1'b0;
      end else begin
         irq_enabled <= 1'b1;
      end
   end
   // Level request held until acknowledged; waiting cycles counted
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         irq_request <= 1'b0;
         irq_wait <= 0;
      end else if (raise_irq && !irq_request) begin
         irq_request <= 1'b1;
         irq_wait <= 0;
      end else if (irq_request && irq_ack) begin
         irq_request <= 1'b0;
      end else if (irq_request) begin
         irq_wait <= irq_wait + 1;
      end
   end
   // Non-maskable event is a single-cycle pulse
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         nmi_request <= 1'b0;
      end else begin
         nmi_request <= fire_nmi && !nmi_request;
      end
   end
endmodule

// file: testbench/tb.sv
`timescale 1ns/100ps
`include "flash_suspend_consts.svh"
`define CHECK(what, exp, got) begin compares++; if ((got) !== (exp)) begin fail_count++; \
   $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got); end end
module tb;
   localparam logic [55:0] ID_CODES = 56'h3C5A0F96E1D24B; // Arbitrary stored codes
   logic clock, reset, reg_write, reg_read, irq_request, irq_enabled, irq_ack, nmi_request, nmi_ack;
   logic flash_reset, mode_drv, mode_pin_out, mode_pin_oe, rxd_in, txd_out, serial_bit_strobe;
   logic serial_mode_sel, single_chip_run, programmer_access, raise_irq, fire_nmi;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, d;
   wire mode_pin_in;
   int irq_wait, fail_count, compares, cycles;
   // Pin level: the block wins while it drives, else the programmer side
   assign mode_pin_in = mode_pin_oe ? mode_pin_out : mode_drv;
   flash_rewrite_suspend_control #(.OP_CYCLES(60), .ID_BYTES(7)) u_flash_rewrite_suspend_control (
      .clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
      .reg_read(reg_read), .reg_rdata(reg_rdata), .irq_request(irq_request), .irq_enabled(irq_enabled),
      .irq_ack(irq_ack), .nmi_request(nmi_request), .nmi_ack(nmi_ack), .flash_reset(flash_reset),
      .mode_pin_in(mode_pin_in), .mode_pin_out(mode_pin_out), .mode_pin_oe(mode_pin_oe), .rxd_in(rxd_in),
      .txd_out(txd_out), .serial_bit_strobe(serial_bit_strobe), .serial_mode_sel(serial_mode_sel),
      .id_stored(ID_CODES), .single_chip_run(single_chip_run), .programmer_access(programmer_access));
   cpu_irq_model u_cpu_irq_model (.clock(clock), .reset(reset), .raise_irq(raise_irq), .fire_nmi(fire_nmi),
      .irq_ack(irq_ack), .irq_request(irq_request), .irq_enabled(irq_enabled), .nmi_request(nmi_request),
      .irq_wait(irq_wait));
   // Clock and hang guard
   always #5 clock = ~clock;
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         tally_and_finish();
      end
   end
   task automatic tally_and_finish();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Register port cycles
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge clock);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clock);
      reg_write <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] v);
      @(posedge clock);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_read <= 1'b0;
      #1 v = reg_rdata;
   endtask
   task automatic wait_ready();
      for (int n = 0; n < 200; n++) begin
         rd(`ADDR_CTRL_STATUS, d);
         if (d[`BIT_READY] === 1'b1) break;
      end
   endtask
   task automatic pulse(input logic nmi);
      @(posedge clock);
      if (nmi) fire_nmi <= 1'b1;
      else raise_irq <= 1'b1;
      @(posedge clock);
      {raise_irq, fire_nmi} <= 2'b00;
   endtask
   task automatic wait_irq_drop();
      for (int n = 0; n < 300; n++) begin
         @(posedge clock);
         #1;
         if (irq_request === 1'b0) break;
      end
   endtask
   task automatic do_reset(input logic pin);
      mode_drv <= pin;
      reset <= 1'b1;
      repeat (4) @(posedge clock);
      reset <= 1'b0;
      repeat (2) @(posedge clock);
   endtask
   task automatic send_id(input logic [55:0] v, input logic on_pin);
      for (int i = 55; i >= 0; i--) begin
         @(posedge clock);
         if (on_pin) mode_drv <= v[i];
         else rxd_in <= v[i];
         repeat (3) @(posedge clock);
         serial_bit_strobe <= 1'b1;
         repeat (4) @(posedge clock);
         serial_bit_strobe <= 1'b0;
      end
      repeat (8) @(posedge clock);
   endtask
   // Scenarios
   task automatic t_reset_map();
      rd(`ADDR_SUSPEND, d);
      `CHECK("suspend after reset", 8'h00, d)
      wr(4'hE, 8'hFF);
      rd(4'hE, d);
      `CHECK("unmapped read", 8'h00, d)
      `CHECK("single chip with pin low", 1'b0, single_chip_run)
      `CHECK("pin not driven mode 2", 1'b0, mode_pin_oe)
   endtask
   task automatic t_enable();
      wr(`ADDR_CTRL_STATUS, 8'h00);
      wr(`ADDR_CTRL_STATUS, 8'h02);
      wr(`ADDR_MODE, 8'h00);
      wr(`ADDR_MODE, 8'h02);
      wr(`ADDR_SUSPEND, 8'h01);
      rd(`ADDR_CTRL_STATUS, d);
      `CHECK("rewrite enable", 8'h02, d & 8'h06)
      rd(`ADDR_MODE, d);
      `CHECK("tolerant select", 1'b1, d[`BIT_TOLERANT])
   endtask
   task automatic t_suspend(input logic [7:0] cmd, input logic [2:0] req);
      wr(`ADDR_COMMAND, cmd);
      repeat (3) @(posedge clock);
      pulse(1'b0);
      wait_irq_drop();
      `CHECK("ack latency", `SUSPEND_LATENCY_CYC + 1, irq_wait)
      rd(`ADDR_SUSPEND, d);
      `CHECK("suspend request set", req | 3'h1, d[2:0])
      rd(`ADDR_CTRL_STATUS, d);
      `CHECK("not ready while paused", 1'b0, d[`BIT_READY])
      wr(`ADDR_SUSPEND, 8'h01);
      wait_ready();
      `CHECK("resumed to completion", 1'b1, d[`BIT_READY])
      rd(`ADDR_SUSPEND, d);
      `CHECK("request cleared", 3'h1, d[2:0])
   endtask
   task automatic t_nosuspend(input logic [7:0] cmd);
      wr(`ADDR_SUSPEND, 8'h00);
      wr(`ADDR_COMMAND, cmd);
      repeat (2) @(posedge clock);
      pulse(1'b0);
      wait_irq_drop();
      `CHECK("ack held till done", 1'b1, irq_wait > 40)
      rd(`ADDR_CTRL_STATUS, d);
      `CHECK("ready at ack", 1'b1, d[`BIT_READY])
      rd(`ADDR_SUSPEND, d);
      `CHECK("no suspend request", 3'h0, d[2:0])
   endtask
   task automatic t_abort();
      int hi;
      hi = 0;
      wr(`ADDR_COMMAND, `CMD_PROGRAM);
      repeat (3) @(posedge clock);
      pulse(1'b1);
      for (int n = 0; n < 100; n++) begin
         @(posedge clock);
         #1;
         if (flash_reset === 1'b1) hi++;
         if (nmi_ack === 1'b1) break;
      end
      `CHECK("flash reset cycles", `ABORT_DELAY_CYC, hi)
      `CHECK("handling start", 1'b1, nmi_ack)
      t_enable();
      wr(`ADDR_COMMAND, `CMD_ERASE);
      wait_ready();
      `CHECK("erase rerun completes", 1'b1, d[`BIT_READY])
   endtask
   task automatic t_serial();
      send_id(ID_CODES, 1'b0);
      `CHECK("mode 2 access", 1'b1, programmer_access)
      `CHECK("mode 2 answer", 1'b1, txd_out)
      rd(`ADDR_ID_STATUS, d);
      `CHECK("id status", 2'h3, d[1:0])
      do_reset(1'b1);
      `CHECK("single chip with pin high", 1'b1, single_chip_run)
      do_reset(1'b0);
      `CHECK("programmer entry with pin low", 1'b0, single_chip_run)
      serial_mode_sel <= 1'b1;
      send_id(ID_CODES ^ 56'h1, 1'b1);
      `CHECK("mode 3 refused", 1'b0, programmer_access)
      `CHECK("mode pin driven", 1'b1, mode_pin_oe)
      `CHECK("mode pin result", 1'b0, mode_pin_out)
   endtask
   initial begin
      clock = 1'b0;
      reset = 1'b1;
      {reg_write, reg_read, mode_drv, rxd_in, serial_bit_strobe, serial_mode_sel} = '0;
      {raise_irq, fire_nmi} = '0;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      {fail_count, compares, cycles} = '0;
      repeat (4) @(posedge clock);
      reset <= 1'b0;
      t_reset_map();
      t_enable();
      t_suspend(`CMD_ERASE, 3'h2);
      t_suspend(`CMD_PROGRAM, 3'h4);
      t_nosuspend(`CMD_ERASE);
      t_nosuspend(`CMD_PROGRAM);
      wr(`ADDR_SUSPEND, 8'h01);
      t_abort();
      t_serial();
      tally_and_finish();
   end
endmodule
